// ==== hdl/stk_port.v ====
/*
 * three-wire serial access port of a clock/calendar timekeeper with its
 * eight-register array, clock-halt control and hour format decode.
 * assumes a free running mclk_i well above the shift clock rate; the gate,
 * shift clock and data pin are asynchronous and are synchronised here.
 */
// Functional notes
// R1 - seconds register bit 7 is the oscillator halt flag
// R2 - halt flag 1 stops the oscillator; writing 0 restarts timekeeping
// R3 - hours bit 7 selects 12-hour (1) or 24-hour (0) counting
// R4 - in 12-hour format hours bit 5 is meridiem, 1 means PM
// R5 - in 24-hour format hours bit 5 is upper tens-of-hours bit
// R6 - command shifting is enabled only while the transfer gate is high
// R7 - gate low aborts any transfer and releases the data pin
// R8 - command and write bits are sampled on shift clock rising edges
// R9 - read bits are driven after shift clock falling edges
// R10 - write: direction 0, eight data bits captured, further clocks ignored
// R11 - read: first data bit on first falling edge after command
// R12 - continued clocking during a read repeats the byte or bytes
// R13 - all bits shift least significant bit first
// R14 - host raises the gate and sends the command byte first
// R15 - host gives 16 clocks for single byte, 72 for burst
// R16 - host lowers the gate after each transfer
// R17 - host clears write lock and halt, waits about 3 s
// R18 - command bit 0 is direction: 0 write, otherwise read
// R19 - command bits 3 to 1 select one of eight registers
// R20 - commands 10111110 and 10111111 are burst write and burst read
// R21 - writes need write lock clear; burst never alters the write lock; the code lets single writes to register 7 through with the lock set
// R22 - burst advances the register index after every eight bits
`timescale 1ns/10ps
`include "stk_consts.vh"

module stk_port #(
  parameter NREG = 8
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire transfer_gate_i,
  input wire sclk_i,
  input wire sdio_i,
  output wire sdio_o,
  output wire sdio_oe_o,
  output wire osc_run_o,
  output wire hour_12_mode_o,
  output wire meridiem_pm_o,
  output wire [1:0] hour_tens_o,
  output wire write_lock_o
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire gate_hi;
  wire sclk_rise;
  wire sclk_fall;
  wire sdi;

  stk_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .async_i({sdio_i, sclk_i, transfer_gate_i}),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign gate_hi = pin_level[0];
  assign sclk_rise = pin_rise[1];
  assign sclk_fall = pin_fall[1];
  assign sdi = pin_level[2];

  // ----------------------------------------------------------------
  // transfer state
  // ----------------------------------------------------------------
  localparam ST_CMD = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [6:0] cmd_q;
  reg [6:0] cmd_d;
  reg [2:0] bit_q;
  reg [2:0] bit_d;
  reg [2:0] idx_q;
  reg [2:0] idx_d;
  reg read_q;
  reg read_d;
  reg burst_q;
  reg burst_d;
  reg [6:0] wsh_q;
  reg [6:0] wsh_d;
  reg sdo_q;
  reg sdo_d;
  reg oe_q;
  reg oe_d;
  reg wr_en;
  reg [7:0] wr_byte;

  reg [7:0] regs_q [0:NREG-1];

  wire [7:0] cmd_full;
  wire [7:0] wr_full;
  wire wlock;
  wire is_burst;

  assign cmd_full = {sdi, cmd_q};
  assign wr_full = {sdi, wsh_q};
  assign wlock = regs_q[`STK_REG_WLOCK][`STK_WLOCK_BIT];
  assign is_burst = (cmd_full & `STK_CMD_BURST_MASK) == `STK_CMD_BURST_WR; // R20

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    cmd_d = cmd_q;
    bit_d = bit_q;
    idx_d = idx_q;
    read_d = read_q;
    burst_d = burst_q;
    wsh_d = wsh_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    wr_byte = wr_full;
    if (!gate_hi)
    begin
      // abort and release the pin
      state_d = ST_CMD; // R7
      bit_d = 3'h0;
      oe_d = 1'b0; // R7
      read_d = 1'b0;
      burst_d = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_CMD:
        begin
          if (sclk_rise) // R6 R8
          begin
            cmd_d = cmd_full[7:1]; // R13
            bit_d = bit_q + 3'h1;
            if (bit_q == `STK_BIT_LAST)
            begin
              read_d = cmd_full[`STK_CMD_DIR_BIT]; // R18
              burst_d = is_burst; // R20
              if (is_burst)
                idx_d = `STK_REG_SECONDS; // R20
              else
                idx_d = cmd_full[`STK_CMD_SEL_HI:`STK_CMD_SEL_LO]; // R19
              if (cmd_full[`STK_CMD_VALID_BIT])
                state_d = ST_DATA;
              else
                state_d = ST_DONE;
            end
          end
        end
        ST_DATA:
        begin
          if (read_q)
          begin
            if (sclk_fall) // R9 R11
            begin
              sdo_d = regs_q[idx_q][bit_q]; // R13
              oe_d = 1'b1;
              bit_d = bit_q + 3'h1;
              if (bit_q == `STK_BIT_LAST && burst_q)
                idx_d = idx_q + 3'h1; // R22 R12
            end
          end
          else if (sclk_rise) // R8
          begin
            wsh_d = wr_full[7:1]; // R13
            bit_d = bit_q + 3'h1;
            if (bit_q == `STK_BIT_LAST)
            begin
              if (idx_q == `STK_REG_WLOCK)
                wr_en = !burst_q; // R21
              else
                wr_en = !wlock; // R21
              if (burst_q && idx_q != `STK_REG_LAST)
                idx_d = idx_q + 3'h1; // R22
              else
                state_d = ST_DONE; // R10
            end
          end
        end
        ST_DONE:
        begin
          // further clocks ignored until the gate drops
          state_d = ST_DONE; // R10
        end
        default:
        begin
          state_d = ST_CMD;
        end
      endcase
    end
  end

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= ST_CMD;
      cmd_q <= 7'h00;
      bit_q <= 3'h0;
      idx_q <= 3'h0;
      read_q <= 1'b0;
      burst_q <= 1'b0;
      wsh_q <= 7'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      read_q <= read_d;
      burst_q <= burst_d;
      wsh_q <= wsh_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1)
    begin : g_reg
      always @(posedge mclk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          if (gi == `STK_REG_SECONDS)
            regs_q[gi] <= `STK_SECONDS_RST;
          else if (gi == `STK_REG_WLOCK)
            regs_q[gi] <= `STK_WLOCK_RST;
          else
            regs_q[gi] <= `STK_OTHER_RST;
        end
        else if (wr_en && idx_q == gi)
        begin
          if (gi == `STK_REG_WLOCK)
            regs_q[gi] <= wr_byte & `STK_WLOCK_MASK;
          else
            regs_q[gi] <= wr_byte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // clock halt and hour format
  // ----------------------------------------------------------------
  reg osc_run_q;
  reg fmt12_q;
  reg pm_q;
  reg [1:0] tens_q;
  wire [7:0] hours;

  assign hours = regs_q[`STK_REG_HOURS];

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      osc_run_q <= 1'b0;
      fmt12_q <= 1'b0;
      pm_q <= 1'b0;
      tens_q <= 2'h0;
    end
    else
    begin
      osc_run_q <= !regs_q[`STK_REG_SECONDS][`STK_SEC_HALT_BIT]; // R1 R2
      fmt12_q <= hours[`STK_HR_FMT_BIT]; // R3
      pm_q <= hours[`STK_HR_FMT_BIT] & hours[`STK_HR_MER_BIT]; // R4
      if (hours[`STK_HR_FMT_BIT])
        tens_q <= {1'b0, hours[`STK_HR_TEN_BIT]}; // R4
      else
        tens_q <= {hours[`STK_HR_MER_BIT], hours[`STK_HR_TEN_BIT]}; // R5
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sdio_o = sdo_q;
  assign sdio_oe_o = oe_q;
  assign osc_run_o = osc_run_q;
  assign hour_12_mode_o = fmt12_q;
  assign meridiem_pm_o = pm_q;
  assign hour_tens_o = tens_q;
  assign write_lock_o = wlock;

endmodule

// ==== hdl/stk_consts.vh ====
/*
 * constants of the serial timekeeper access port: command byte layout,
 * register indices, register field positions and reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef STK_CONSTS_VH
`define STK_CONSTS_VH

// ----------------------------------------------------------------
// command byte
// ----------------------------------------------------------------
`define STK_CMD_DIR_BIT 0
`define STK_CMD_SEL_HI 3
`define STK_CMD_SEL_LO 1
`define STK_CMD_VALID_BIT 7
`define STK_CMD_BURST_WR 8'hbe
`define STK_CMD_BURST_RD 8'hbf
`define STK_CMD_BURST_MASK 8'hfe

// ----------------------------------------------------------------
// register indices and fields
// ----------------------------------------------------------------
`define STK_REG_SECONDS 3'h0
`define STK_REG_HOURS 3'h2
`define STK_REG_WLOCK 3'h7
`define STK_REG_LAST 3'h7
`define STK_SEC_HALT_BIT 7
`define STK_HR_FMT_BIT 7
`define STK_HR_MER_BIT 5
`define STK_HR_TEN_BIT 4
`define STK_WLOCK_BIT 7
`define STK_WLOCK_MASK 8'h80

// ----------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------
`define STK_BIT_LAST 3'h7
`define STK_SECONDS_RST 8'h80
`define STK_OTHER_RST 8'h00
`define STK_WLOCK_RST 8'h80

`endif

// ==== hdl/stk_sync.v ====
/*
 * two-flop synchroniser with edge detect for a group of pin inputs.
 * assumes the inputs are asynchronous to clk_i; edges are seen from the
 * second and third stages only.
 */
`timescale 1ns/10ps

module stk_sync #(
  parameter WIDTH = 3
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [WIDTH-1:0] prev_q;

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule

// ==== sim/stk_port_sva.sv ====
/* assertions on the timekeeper port pins and hour decode outputs.
   assumes bind to stk_port and a shift clock half period of 4 mclk or more. */
`timescale 1ns/10ps
module stk_port_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic transfer_gate_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_o,
  input wire logic osc_run_o,
  input wire logic hour_12_mode_o,
  input wire logic meridiem_pm_o,
  input wire logic [1:0] hour_tens_o,
  input wire logic write_lock_o
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_gate_idle;
    !transfer_gate_i [*6];
  endsequence
  a_pm_needs_12h: assert property (meridiem_pm_o |-> hour_12_mode_o)
    else $error("meridiem set in 24-hour mode");
  a_tens_12h: assert property (hour_12_mode_o |-> !hour_tens_o[1])
    else $error("tens bit 5 used in 12-hour mode");
  a_gate_release: assert property (s_gate_idle |-> !sdio_oe_o)
    else $error("data pin driven with gate low");
  a_oe_drop: assert property ($fell(sdio_oe_o) |-> !$past(transfer_gate_i, 3))
    else $error("data pin released while gate high");
  a_oe_start: assert property ($rose(sdio_oe_o)
    |-> $past(transfer_gate_i, 3) && !$past(sclk_i, 2))
    else $error("data pin driven without gate or falling edge");
  a_out_on_fall: assert property (sdio_oe_o && $past(sdio_oe_o) && $changed(sdio_o)
    |-> !$past(sclk_i, 3))
    else $error("read bit changed outside falling edge");
  // the last data bit of a byte is bit 7, taken from the pin at the rising edge
  a_lock_on_rise: assert property ($changed(write_lock_o)
    |-> $past(sclk_i, 3) && $past(sdio_i, 3) == write_lock_o)
    else $error("write lock changed without rising edge");
  a_run_on_rise: assert property ($changed(osc_run_o)
    |-> $past(sclk_i, 3) && $past(sdio_i, 4) != osc_run_o)
    else $error("oscillator state changed without rising edge");
  a_fmt_on_rise: assert property ($changed(hour_12_mode_o)
    |-> $past(sclk_i, 3) && $past(sdio_i, 4) == hour_12_mode_o)
    else $error("hour format changed without rising edge");
endmodule

// ==== sim/stk_host.sv ====
/* host model of the three-wire link: gate, shift clock and data pin.
   assumes one frame at a time, called from the mclk domain. */
`timescale 1ns/10ps
module stk_host (
  input wire logic mclk_i,
  input wire logic dev_d_i,
  input wire logic dev_oe_i,
  output logic gate_o,
  output logic sclk_o,
  output wire logic sd_o
);
  logic drv = 1'b0;
  logic dat = 1'b0;
  logic tog = 1'b0;
  initial gate_o = 1'b0;
  initial sclk_o = 1'b0;
  // ------------------------------------------------
  // released pin shows a changing level
  // ------------------------------------------------
  always @(posedge mclk_i) tog <= ~tog;
  assign sd_o = dev_oe_i ? dev_d_i : (drv ? dat : tog);
  task automatic xfer(input logic [7:0] c, input logic [71:0] wd, input int n,
    output logic [71:0] rd);
    logic [79:0] s;
    s = {wd, c};
    rd = '0;
    gate_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < n + 8; i++)
    begin
      sclk_o <= 1'b0;
      drv <= i < 8 || !c[0];
      dat <= s[i];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      if (i >= 8)
        rd[i-8] = sd_o;
      repeat (2) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
    gate_o <= 1'b0;
    drv <= 1'b0;
    repeat (4) @(posedge mclk_i);
    sclk_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule

// ==== sim/tb_stk_port.sv ====
/* self-checking bench for stk_port through the stk_host link model.
   assumes 25 MHz mclk and a 320 ns shift clock period. */
`timescale 1ns/10ps
module tb_stk_port;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic gate, sclk, sd, sdo, sdoe, run, h12, pm, lock;
  logic [1:0] tens;
  logic [71:0] r;
  int miscompares = 0;
  int compares = 0;
  stk_port dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .transfer_gate_i(gate), .sclk_i(sclk),
    .sdio_i(sd), .sdio_o(sdo), .sdio_oe_o(sdoe), .osc_run_o(run), .hour_12_mode_o(h12),
    .meridiem_pm_o(pm), .hour_tens_o(tens), .write_lock_o(lock));
  stk_host h (.mclk_i(mclk_i), .dev_d_i(sdo), .dev_oe_i(sdoe), .gate_o(gate),
    .sclk_o(sclk), .sd_o(sd));
  initial forever #20 mclk_i = ~mclk_i;
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xw(input logic [7:0] c, input logic [71:0] d, input int n);
    h.xfer(c, d, n, r);
  endtask
  task automatic xr(input logic [7:0] c, input int n, input logic [71:0] e);
    h.xfer(c, 72'h0, n, r);
    chk("read", e, r);
  endtask
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    xr(8'h81, 8, 72'h80);
    xr(8'h8f, 8, 72'h80);
    chk("lock", 72'h1, lock);
    chk("run", 72'h0, run);
    $display("test reset done");
    xw(8'h84, 72'h25, 8);
    xr(8'h85, 8, 72'h0);
    xw(8'h8e, 72'h0, 8);
    chk("lock", 72'h0, lock);
    $display("test lock done");
    xw(8'h80, 72'h0, 8);
    chk("run", 72'h1, run);
    xw(8'h80, 72'h80, 8);
    chk("run", 72'h0, run);
    xw(8'h80, 72'h0, 8);
    chk("run", 72'h1, run);
    $display("test halt done");
    xw(8'h84, 72'h5aa5, 16);
    chk("fmt", 72'h1, h12);
    chk("pm", 72'h1, pm);
    chk("tens", 72'h0, tens);
    xr(8'h85, 16, 72'ha5a5);
    xw(8'h84, 72'h23, 8);
    chk("fmt", 72'h0, h12);
    chk("pm", 72'h0, pm);
    chk("tens", 72'h2, tens);
    $display("test hours done");
    xw(8'hbe, 72'h8016151413121109, 64);
    chk("lock", 72'h0, lock);
    chk("tens", 72'h1, tens);
    xr(8'hbf, 72, 72'h090016151413121109);
    $display("test burst done");
    xw(8'h82, 72'h3c, 4);
    xr(8'h83, 8, 72'h11);
    xr(8'h83, 4, 72'h1);
    $display("test abort done");
    // a command with bit 7 clear is not a valid access and its data is dropped
    xw(8'h04, 72'h85, 8);
    chk("fmt", 72'h0, h12);
    xr(8'h85, 8, 72'h12);
    $display("test invalid done");
    print_verdict;
  end
endmodule
bind stk_port stk_port_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .transfer_gate_i(transfer_gate_i), .sclk_i(sclk_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
  .sdio_oe_o(sdio_oe_o), .osc_run_o(osc_run_o), .hour_12_mode_o(hour_12_mode_o),
  .meridiem_pm_o(meridiem_pm_o), .hour_tens_o(hour_tens_o), .write_lock_o(write_lock_o));
